// file: rtl/cosim_pkg.sv
// Shared constants for the co-simulation wrapper: frame layout, opcodes,
// register offsets, reset values and the command processor states.
// Assumes nothing of its surroundings; the clock controller and the wrapper refer to it by name.
package cosim_pkg;

  // ----------------------------------------------------------------------
  // Host link frame
  // ----------------------------------------------------------------------
  localparam int          FRAME_BITS  = 40;
  localparam int          CNT_W       = 6;
  localparam logic [5:0]  FRAME_LEN   = 6'h28;
  localparam int          OP_LSB      = 38;
  localparam int          ADDR_LSB    = 32;
  localparam int          CMD_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    OP_NOP   = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_RUN   = 2'b11
  } opcode_e;

  // ----------------------------------------------------------------------
  // Register bank reached by host commands
  // ----------------------------------------------------------------------
  localparam logic [5:0]  BANK_DATA_IN   = 6'h00;
  localparam logic [5:0]  BANK_DATA_OUT  = 6'h04;
  localparam logic [5:0]  BANK_CLK_CTRL  = 6'h08;
  localparam logic [5:0]  BANK_STATUS    = 6'h0C;
  localparam logic [31:0] RUN_INFINITE   = 32'hFFFF_FFFF;
  localparam logic [31:0] RUN_STOP       = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Local software registers on the Avalon-MM slave
  // ----------------------------------------------------------------------
  localparam logic [3:0]  AV_CONFIG      = 4'h0;
  localparam logic [3:0]  AV_STATUS      = 4'h4;
  localparam logic [3:0]  AV_REMAINING   = 4'h8;
  localparam logic [3:0]  AV_CMD_COUNT   = 4'hC;
  localparam int          CFG_FREE_EN    = 0;
  localparam int          CFG_OVR_CLR    = 1;
  localparam logic        CFG_FREE_RESET = 1'b0;

  typedef enum logic [2:0] {
    PS_IDLE  = 3'b000,
    PS_WRITE = 3'b001,
    PS_WRESP = 3'b010,
    PS_READ  = 3'b011,
    PS_RDATA = 3'b100,
    PS_REPLY = 3'b101
  } proc_e;

endpackage

// file: rtl/cosim_fifo.sv
// Synchronous first-word-fall-through FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset shared with its user.
`timescale 1ns/1ps
module cosim_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 level;
  } fifo_s;

  fifo_s st_r;
  fifo_s st_nxt;
  logic  doPush;
  logic  doPop;

  assign inReady  = (st_r.level != (AW+1)'(DEPTH));
  assign outValid = (st_r.level != '0);
  assign outData  = st_r.mem[st_r.rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    st_nxt = st_r;
    if (doPush)
    begin
      st_nxt.mem[st_r.wrPtr] = inData;
      st_nxt.wrPtr = (st_r.wrPtr == AW'(DEPTH-1)) ? '0 : st_r.wrPtr + 1'b1;
    end
    if (doPop)
    begin
      st_nxt.rdPtr = (st_r.rdPtr == AW'(DEPTH-1)) ? '0 : st_r.rdPtr + 1'b1;
    end
    if (doPush && !doPop)
    begin
      st_nxt.level = st_r.level + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      st_nxt.level = st_r.level - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: rtl/dut_clock_ctrl.sv
// Clock generator for the device under test: counted pulses, free run or stop.
// Assumes the caller holds stall while a pulse would starve or flood a FIFO.
`timescale 1ns/1ps
module dut_clock_ctrl #(
  parameter int PULSES_PER_STEP = 1
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        load,
  input  wire logic [31:0] count,
  input  wire logic        freeAllowed,
  input  wire logic        stall,
  output logic             dutClk,
  output logic             riseStrobe,
  output logic             fallStrobe,
  output logic             running,
  output logic             freeRun,
  output logic [31:0]      remaining
);
  typedef struct packed {
    logic        clk;
    logic        rise;
    logic        fall;
    logic        free;
    logic [31:0] left;
  } clk_s;

  clk_s st_r;
  clk_s st_nxt;

  assign dutClk     = st_r.clk;
  assign riseStrobe = st_r.rise;
  assign fallStrobe = st_r.fall;
  assign freeRun    = st_r.free;
  assign remaining  = st_r.left;
  assign running    = st_r.free || (st_r.left != '0) || st_r.clk;

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    // The clock is a flip-flop output whose high and low phases each last a
    // whole cycle, so a stop or an expiring count never clips a pulse.
    if (st_r.clk)
    begin
      st_nxt.clk  = 1'b0;
      st_nxt.fall = 1'b1;
    end
    else if ((st_r.free || st_r.left != '0) && !stall)
    begin
      st_nxt.clk  = 1'b1;
      st_nxt.rise = 1'b1;
      if (!st_r.free)
      begin
        st_nxt.left = st_r.left - 1'b1;
      end
    end
    if (load)
    begin
      if (count == cosim_pkg::RUN_STOP)
      begin
        st_nxt.free = 1'b0;
        st_nxt.left = '0;
      end
      else if (count == cosim_pkg::RUN_INFINITE)
      begin
        st_nxt.free = freeAllowed;
        st_nxt.left = '0;
      end
      else
      begin
        st_nxt.free = 1'b0;
        st_nxt.left = 32'(count * 32'(PULSES_PER_STEP));
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: rtl/cosim_wrapper.sv
// Co-simulation wrapper: serial host link, command FIFO, command processor,
// internal AXI4-Lite register bank, DUT clock control and burst FIFOs.
// Assumes the host link pins come from another clock domain and that the DUT
// is clocked only by dutClk, which is made from core_clk here.
//
// How it works
// - Single-step runs give PULSES_PER_STEP clock pulses per host step.
// - Free-run mode keeps the DUT clock toggling without host activity.
// - In free run, port reads and writes act at once, unaligned.
// - Command frames arrive over the serial link; responses return on it.
// - Each command is decoded and executed on the register bank.
// - Write commands load the input register that drives the DUT input.
// - Read commands return the register holding the DUT output.
// - Run with count x issues exactly x times PULSES_PER_STEP pulses, then stops.
// - Run with all ones free-runs; run with zero stops the clock.
// - With burst built in, DUT ports go through FIFOs of depth n.
// - Host fills input FIFO; run consumes one sample per port sample time.
// - Burst run pushes output samples, held until the host drains them.
// - Clock mode is fixed before a run and cannot change during it.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cosim_wrapper #(
  parameter int DUT_IN_W        = 32,
  parameter int DUT_OUT_W       = 32,
  parameter bit BURST_MODE      = 1'b0,
  parameter int BURST_DEPTH     = 1024,
  parameter int PORT_RATE       = 1,
  parameter int PULSES_PER_STEP = 1,
  parameter bit FREE_RUN_OK     = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire logic                 linkClk,
  input  wire logic                 linkSel,
  input  wire logic                 linkDin,
  output logic                      linkDout,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      dutClk,
  output logic [DUT_IN_W-1:0]       dutIn,
  input  wire logic [DUT_OUT_W-1:0] dutOut,
  input  wire logic                 dutFlag
);
  localparam int FB = cosim_pkg::FRAME_BITS;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            clkSync;
    logic [1:0]            selSync;
    logic [1:0]            dinSync;
    logic [1:0]            flagSync;
    logic                  clkPrev;
    logic [FB-1:0]         rxShift;
    logic [5:0]            rxCount;
    logic [FB-1:0]         txShift;
    logic                  overrun;
    cosim_pkg::proc_e      state;
    logic [FB-1:0]         cmd;
    logic [31:0]           result;
    logic                  bValid;
    logic                  rValid;
    logic [31:0]           rData;
    logic [DUT_IN_W-1:0]   dutIn;
    logic                  freeEn;
    logic                  avAck;
    logic [31:0]           avData;
    logic [31:0]           cmdCount;
    logic [15:0]           rateCnt;
  } wrap_s;

  wrap_s st_r;
  wrap_s st_nxt;

  // Link edge detect, command FIFO and processor handshakes.
  logic                  linkRise;
  logic                  linkFall;
  logic                  frameDone;
  logic                  cmdInReady;
  logic                  cmdValid;
  logic [FB-1:0]         cmdData;
  logic                  cmdPop;
  // Internal AXI4-Lite bank channel.
  logic                  awValid;
  logic                  wValid;
  logic                  awReady;
  logic                  bReady;
  logic                  arValid;
  logic                  arReady;
  logic                  rReady;
  logic [5:0]            bankAddr;
  logic [31:0]           bankWdata;
  logic                  writeAccept;
  logic                  readAccept;
  // Clock controller and burst FIFOs.
  logic                  clkLoad;
  logic                  clkRise;
  logic                  clkFall;
  logic                  clkRunning;
  logic                  clkFree;
  logic [31:0]           clkLeft;
  logic                  stall;
  logic                  sampleEdge;
  logic                  inPush;
  logic                  inFifoReady;
  logic                  inFifoValid;
  logic [DUT_IN_W-1:0]   inFifoData;
  logic                  inPop;
  logic                  outPush;
  logic                  outFifoReady;
  logic                  outFifoValid;
  logic [DUT_OUT_W-1:0]  outFifoData;
  logic                  outPop;
  logic [7:0]            respFlags;

  // ----------------------------------------------------------------------
  // Host link framing
  // ----------------------------------------------------------------------
  // Only the second synchroniser stage and the stored previous level feed
  // the edge detector, so a metastable first stage never reaches logic.
  assign linkRise  = st_r.clkSync[1] && !st_r.clkPrev;
  assign linkFall  = !st_r.clkSync[1] && st_r.clkPrev;
  assign frameDone = linkRise && st_r.selSync[1] && (st_r.rxCount == cosim_pkg::FRAME_LEN);
  assign linkDout  = st_r.txShift[0];

  cosim_fifo #(
    .WIDTH (FB),
    .DEPTH (cosim_pkg::CMD_FIFO_DEPTH)
  ) u_cmd_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inData   (st_r.rxShift),
    .inValid  (frameDone),
    .inReady  (cmdInReady),
    .outData  (cmdData),
    .outValid (cmdValid),
    .outReady (cmdPop)
  );

  // ----------------------------------------------------------------------
  // Command processor as AXI4-Lite master
  // ----------------------------------------------------------------------
  assign cmdPop    = (st_r.state == cosim_pkg::PS_IDLE) && cmdValid;
  assign bankAddr  = st_r.cmd[cosim_pkg::OP_LSB-1:cosim_pkg::ADDR_LSB];
  assign bankWdata = st_r.cmd[31:0];
  assign awValid   = (st_r.state == cosim_pkg::PS_WRITE);
  assign wValid    = awValid;
  assign bReady    = (st_r.state == cosim_pkg::PS_WRESP);
  assign arValid   = (st_r.state == cosim_pkg::PS_READ);
  assign rReady    = (st_r.state == cosim_pkg::PS_RDATA);
  // Write address and data are accepted together; one transfer in flight.
  assign awReady     = !st_r.bValid;
  assign arReady     = !st_r.rValid;
  assign writeAccept = awValid && wValid && awReady;
  assign readAccept  = arValid && arReady;

  // ----------------------------------------------------------------------
  // Register bank side effects
  // ----------------------------------------------------------------------
  assign clkLoad = writeAccept && (bankAddr == cosim_pkg::BANK_CLK_CTRL);
  assign inPush  = BURST_MODE && writeAccept && (bankAddr == cosim_pkg::BANK_DATA_IN);
  assign outPop  = BURST_MODE && readAccept && (bankAddr == cosim_pkg::BANK_DATA_OUT) && outFifoValid;
  assign sampleEdge = (st_r.rateCnt == 16'(PORT_RATE - 1));
  // A sample is consumed and produced on the falling half of a pulse, when the
  // DUT has already taken its input and its registered output has settled.
  assign inPop   = BURST_MODE && clkFall && sampleEdge;
  assign outPush = BURST_MODE && clkFall && sampleEdge;
  assign stall   = BURST_MODE && sampleEdge && (!inFifoValid || !outFifoReady);
  assign dutIn   = BURST_MODE ? inFifoData : st_r.dutIn;

  cosim_fifo #(
    .WIDTH (DUT_IN_W),
    .DEPTH (BURST_DEPTH)
  ) u_in_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inData   (bankWdata[DUT_IN_W-1:0]),
    .inValid  (inPush),
    .inReady  (inFifoReady),
    .outData  (inFifoData),
    .outValid (inFifoValid),
    .outReady (inPop)
  );

  cosim_fifo #(
    .WIDTH (DUT_OUT_W),
    .DEPTH (BURST_DEPTH)
  ) u_out_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inData   (dutOut),
    .inValid  (outPush),
    .inReady  (outFifoReady),
    .outData  (outFifoData),
    .outValid (outFifoValid),
    .outReady (outPop)
  );

  dut_clock_ctrl #(
    .PULSES_PER_STEP (PULSES_PER_STEP)
  ) u_clk_ctrl (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .load        (clkLoad),
    .count       (bankWdata),
    .freeAllowed (st_r.freeEn),
    .stall       (stall),
    .dutClk      (dutClk),
    .riseStrobe  (clkRise),
    .fallStrobe  (clkFall),
    .running     (clkRunning),
    .freeRun     (clkFree),
    .remaining   (clkLeft)
  );

  assign respFlags = {st_r.overrun, st_r.flagSync[1], clkRunning, clkFree,
                      inFifoReady, outFifoValid, 2'b00};

  // ----------------------------------------------------------------------
  // Avalon-MM slave: one wait state, answer on the second edge
  // ----------------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.avAck;
  assign avs_readdata    = st_r.avData;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.clkSync  = {st_r.clkSync[0], linkClk};
    st_nxt.selSync  = {st_r.selSync[0], linkSel};
    st_nxt.dinSync  = {st_r.dinSync[0], linkDin};
    st_nxt.flagSync = {st_r.flagSync[0], dutFlag};
    st_nxt.clkPrev  = st_r.clkSync[1];

    // Receive: bits shift in while selected; a frame ends when the select
    // line is seen released on a link clock rise after at least 40 bits.
    if (linkRise)
    begin
      if (!st_r.selSync[1])
      begin
        st_nxt.rxShift = {st_r.dinSync[1], st_r.rxShift[FB-1:1]};
        if (st_r.rxCount != cosim_pkg::FRAME_LEN)
        begin
          st_nxt.rxCount = st_r.rxCount + 1'b1;
        end
      end
      else
      begin
        st_nxt.rxCount = '0;
      end
    end
    if (linkFall && !st_r.selSync[1])
    begin
      st_nxt.txShift = {1'b0, st_r.txShift[FB-1:1]};
    end

    // A frame arriving with the command FIFO full is dropped and flagged.
    // Setting wins over a simultaneous software clear.
    if (avs_write && st_r.avAck && avs_address == cosim_pkg::AV_CONFIG
        && avs_writedata[cosim_pkg::CFG_OVR_CLR])
    begin
      st_nxt.overrun = 1'b0;
    end
    if ((frameDone && !cmdInReady) || (inPush && !inFifoReady))
    begin
      st_nxt.overrun = 1'b1;
    end

    // Bank slave responses.
    if (writeAccept)
    begin
      st_nxt.bValid = 1'b1;
      if (!BURST_MODE && bankAddr == cosim_pkg::BANK_DATA_IN)
      begin
        st_nxt.dutIn = bankWdata[DUT_IN_W-1:0];
      end
    end
    else if (st_r.bValid && bReady)
    begin
      st_nxt.bValid = 1'b0;
    end
    if (readAccept)
    begin
      st_nxt.rValid = 1'b1;
      if (bankAddr == cosim_pkg::BANK_DATA_OUT)
      begin
        if (BURST_MODE)
        begin
          st_nxt.rData = outFifoValid ? 32'(outFifoData) : '0;
        end
        else
        begin
          st_nxt.rData = 32'(dutOut);
        end
      end
      else if (bankAddr == cosim_pkg::BANK_CLK_CTRL)
      begin
        st_nxt.rData = clkLeft;
      end
      else if (bankAddr == cosim_pkg::BANK_STATUS)
      begin
        st_nxt.rData = {24'h00_0000, respFlags};
      end
      else if (bankAddr == cosim_pkg::BANK_DATA_IN)
      begin
        st_nxt.rData = BURST_MODE ? 32'(inFifoData) : 32'(st_r.dutIn);
      end
      else
      begin
        st_nxt.rData = '0;
      end
    end
    else if (st_r.rValid && rReady)
    begin
      st_nxt.rValid = 1'b0;
    end

    // Command processor: one command at a time, each access completes
    // through its response channel before the next command is popped.
    case (st_r.state)
      cosim_pkg::PS_IDLE:
      begin
        if (cmdValid)
        begin
          st_nxt.cmd      = cmdData;
          st_nxt.result   = '0;
          st_nxt.cmdCount = st_r.cmdCount + 1'b1;
          case (cosim_pkg::opcode_e'(cmdData[FB-1:cosim_pkg::OP_LSB]))
            cosim_pkg::OP_WRITE: st_nxt.state = cosim_pkg::PS_WRITE;
            cosim_pkg::OP_READ:  st_nxt.state = cosim_pkg::PS_READ;
            cosim_pkg::OP_RUN:
            begin
              st_nxt.cmd[cosim_pkg::OP_LSB-1:cosim_pkg::ADDR_LSB] = cosim_pkg::BANK_CLK_CTRL;
              st_nxt.state = cosim_pkg::PS_WRITE;
            end
            default:             st_nxt.state = cosim_pkg::PS_REPLY;
          endcase
        end
      end
      cosim_pkg::PS_WRITE:
      begin
        if (writeAccept)
        begin
          st_nxt.state = cosim_pkg::PS_WRESP;
        end
      end
      cosim_pkg::PS_WRESP:
      begin
        if (st_r.bValid)
        begin
          st_nxt.state = cosim_pkg::PS_REPLY;
        end
      end
      cosim_pkg::PS_READ:
      begin
        if (readAccept)
        begin
          st_nxt.state = cosim_pkg::PS_RDATA;
        end
      end
      cosim_pkg::PS_RDATA:
      begin
        if (st_r.rValid)
        begin
          st_nxt.result = st_r.rData;
          st_nxt.state  = cosim_pkg::PS_REPLY;
        end
      end
      cosim_pkg::PS_REPLY:
      begin
        // The response is shifted out during the host's next frame.
        st_nxt.txShift = {respFlags, st_r.result};
        st_nxt.state   = cosim_pkg::PS_IDLE;
      end
      default:
      begin
        st_nxt.state = cosim_pkg::PS_IDLE;
      end
    endcase

    // Port sample time divider for burst runs.
    if (clkFall)
    begin
      st_nxt.rateCnt = sampleEdge ? '0 : st_r.rateCnt + 1'b1;
    end
    if (clkLoad)
    begin
      st_nxt.rateCnt = '0;
    end

    // Avalon slave. The mode bit is frozen while the DUT clock runs.
    st_nxt.avAck = (avs_read || avs_write) && !st_r.avAck;
    if (avs_read && !st_r.avAck)
    begin
      if (avs_address == cosim_pkg::AV_CONFIG)
      begin
        st_nxt.avData = {31'h0000_0000, st_r.freeEn};
      end
      else if (avs_address == cosim_pkg::AV_STATUS)
      begin
        st_nxt.avData = {24'h00_0000, respFlags[7:2],
                         (st_r.state != cosim_pkg::PS_IDLE), cmdValid};
      end
      else if (avs_address == cosim_pkg::AV_REMAINING)
      begin
        st_nxt.avData = clkLeft;
      end
      else if (avs_address == cosim_pkg::AV_CMD_COUNT)
      begin
        st_nxt.avData = st_r.cmdCount;
      end
      else
      begin
        st_nxt.avData = '0;
      end
    end
    if (avs_write && st_r.avAck && avs_address == cosim_pkg::AV_CONFIG && !clkRunning)
    begin
      st_nxt.freeEn = avs_writedata[cosim_pkg::CFG_FREE_EN] && FREE_RUN_OK;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r        <= '0;
      st_r.state  <= cosim_pkg::PS_IDLE;
      st_r.freeEn <= cosim_pkg::CFG_FREE_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// file: bench/cosim_wrapper_properties.sv
// Port checker for the co-simulation wrapper: register bus and DUT clock.
// Assumes it is bound to cosim_wrapper and that the bus master holds requests.
`timescale 1ns/1ps
module cosim_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        dutClk
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read not held off");
  wr_wait_a: assert property ($rose(avs_write) |-> avs_waitrequest) else $error("write not held off");
  rd_ans_a: assert property (avs_read && avs_waitrequest ##1 avs_read |-> !avs_waitrequest) else $error("read late");
  wr_ans_a: assert property (avs_write && avs_waitrequest ##1 avs_write |-> !avs_waitrequest) else $error("late");
  idle_go_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest) else $error("idle stall");
  rdata_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata)) else $error("read data moved");
  pulse_width_a: assert property (dutClk |=> !dutClk) else $error("clock high too long");
  ack_req_a: assert property ($fell(avs_waitrequest) |-> avs_read || avs_write) else $error("stray ack");
  c_pulse: cover property ($rose(dutClk));
  c_read: cover property (avs_read && !avs_waitrequest);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind cosim_wrapper cosim_checker cosim_checker_inst (.core_clk(core_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dutClk(dutClk));

// file: bench/host_link_model.sv
// Host end of the serial command link: one frame out, previous answer in.
// Assumes the wrapper answers a frame during the frame that follows it.
`timescale 1ns/1ps
module host_link_model (
  output logic      linkClk,
  output logic      linkSel,
  output logic      linkDin,
  input  wire logic linkDout
);
  initial
  begin
    linkClk = 1'b0;
    linkSel = 1'b1;
    linkDin = 1'b0;
  end
  // Each frame ends with one clock pulse while select is released and data flips, so stale bits never look valid.
  task automatic xfer(input logic [39:0] f, output logic [39:0] r);
    for (int i = 0; i < 40; i++)
    begin
      linkSel = 1'b0;
      linkDin = f[i];
      #80 linkClk = 1'b1;
      r[i] = linkDout;
      #80 linkClk = 1'b0;
    end
    linkSel = 1'b1;
    linkDin = ~linkDin;
    #80 linkClk = 1'b1;
    #80 linkClk = 1'b0;
  endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the co-simulation wrapper.
// Assumes the host link model and the bound port checker.
`timescale 1ns/1ps
module tb;
  logic        core_clk, resetn, linkClk, linkSel, linkDin, linkDout;
  logic        avs_read, avs_write, avs_waitrequest, dutClk, dutFlag;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, dutIn, dutOut, q;
  logic [39:0] rsp;
  int          errors, comparisons, rises;
  cosim_wrapper cosim_wrapper_inst (.core_clk, .resetn, .linkClk, .linkSel, .linkDin, .linkDout, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .dutClk, .dutIn, .dutOut, .dutFlag);
  host_link_model host_link_model_inst (.linkClk, .linkSel, .linkDin, .linkDout);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge dutClk) rises++;
  task automatic test_done;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // The request stands until the rising edge that sees waitrequest low; read data is taken at that edge.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50)
    begin
      errors++;
      test_done();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_regs;
    av(0, cosim_pkg::AV_CONFIG, 0);
    chk("config", 0, q);
    av(1, 4'h2, 32'hFFFF_FFFF);
    av(0, 4'h2, 0);
    chk("unmapped", 0, q);
    av(1, cosim_pkg::AV_CONFIG, 1);
    av(0, cosim_pkg::AV_CONFIG, 0);
    chk("free_en", 1, q[0]);
  endtask
  task automatic t_write;
    host_link_model_inst.xfer({cosim_pkg::OP_WRITE, cosim_pkg::BANK_DATA_IN, 32'h1234_5678}, rsp);
    cyc(20);
    chk("dutIn", 32'h1234_5678, dutIn);
  endtask
  task automatic t_read;
    dutOut <= 32'hA5A5_0F0F;
    host_link_model_inst.xfer({cosim_pkg::OP_READ, cosim_pkg::BANK_DATA_OUT, 32'h0000_0000}, rsp);
    cyc(20);
    host_link_model_inst.xfer({cosim_pkg::OP_NOP, 6'h00, 32'h0000_0000}, rsp);
    chk("dutOut", 32'hA5A5_0F0F, rsp[31:0]);
  endtask
  task automatic t_run;
    rises = 0;
    host_link_model_inst.xfer({cosim_pkg::OP_RUN, cosim_pkg::BANK_CLK_CTRL, 32'h0000_0005}, rsp);
    cyc(100);
    chk("pulses", 5, rises);
    av(0, cosim_pkg::AV_REMAINING, 0);
    chk("remaining", 0, q);
  endtask
  task automatic t_free;
    host_link_model_inst.xfer({cosim_pkg::OP_RUN, cosim_pkg::BANK_CLK_CTRL, cosim_pkg::RUN_INFINITE}, rsp);
    cyc(40);
    rises = 0;
    cyc(40);
    chk("free_run", 1, rises > 10);
    av(1, cosim_pkg::AV_CONFIG, 0);
    av(0, cosim_pkg::AV_CONFIG, 0);
    chk("mode_kept", 1, q[0]);
    av(0, cosim_pkg::AV_STATUS, 0);
    chk("running", 1, q[5]);
    host_link_model_inst.xfer({cosim_pkg::OP_RUN, cosim_pkg::BANK_CLK_CTRL, cosim_pkg::RUN_STOP}, rsp);
    cyc(20);
    rises = 0;
    cyc(40);
    chk("stopped", 0, rises);
  endtask
  initial
  begin
    {errors, comparisons, rises} = '0;
    {resetn, avs_read, avs_write, dutFlag} = '0;
    {avs_address, avs_writedata, dutOut} = '0;
    cyc(10);
    resetn <= 1'b1;
    cyc(3);
    t_regs();
    t_write();
    t_read();
    t_run();
    t_free();
    dutFlag <= 1'b1;
    cyc(5);
    av(0, cosim_pkg::AV_STATUS, 0);
    chk("flag", 1, q[6]);
    test_done();
  end
endmodule
